// >>> hdl/i2c_flag_ctrl_map.vh
`ifndef I2C_FLAG_CTRL_MAP_VH
`define I2C_FLAG_CTRL_MAP_VH

// Memory-mapped register addresses
`define ADDR_BUS_FLAG 16'hffab
`define ADDR_CLK_SEL 16'hff48
`define ADDR_FUNC_EXP 16'hffa9
`define ADDR_IF_CTRL 16'hffaa

// Reset values
`define RST_BUS_FLAG 8'h00
`define RST_CLK_SEL 8'h00
`define RST_FUNC_EXP 8'h00
`define RST_IF_CTRL 8'h00

// Bus flag register fields
`define BF_START_FAIL 7
`define BF_BUS_BUSY 6
`define BF_INIT_START 1
`define BF_RSV_DIS 0

// Interface control register fields
`define IC_ENABLE 7
`define IC_START_REQ 1

// Transfer clock select register fields
`define CS_CLK_LEVEL 5
`define CS_DATA_LEVEL 4
`define CS_SPEED_MODE 3
`define CS_FILTER 2
`define CS_DIV_HI 1
`define CS_DIV_LO 0
`define CS_WRITE_MASK 8'h0f

// Function expansion register fields
`define FX_CLK_EXP 0
`define FX_WRITE_MASK 8'h01

// Prescale counts of the selection clock
`define PRE_DIV2 3'h2
`define PRE_DIV4 3'h4

// Transfer clock divide ratios, selection clock cycles per bit
`define M_44 7'h2c
`define M_86 7'h56
`define M_66 7'h42
`define M_24 7'h18
`define M_18 7'h12
`define M_12 7'h0c

`endif

// >>> hdl/xfer_clock_gen.v
`timescale 1ns/1ps
`include "i2c_flag_ctrl_map.vh"

module xfer_clock_gen (
   input wire clock,        // System clock
   input wire reset,        // Synchronous reset, active high
   input wire run,          // Interface enabled
   input wire speed_mode,   // High-speed mode select
   input wire div_hi,       // Divider select upper bit
   input wire div_lo,       // Divider select lower bit
   input wire expansion,    // Clock expansion bit
   input wire ext_clk,      // External selection clock, sampled
   output reg xfer_clk,     // Transfer clock level
   output reg clk_valid     // Setting is legal and clock is running
);

   reg [2:0] pre_sel;
   reg use_ext;
   reg [6:0] ratio;
   reg legal;
   reg [2:0] pre_cnt_reg;
   reg ext_prev_reg;
   reg [5:0] half_cnt_reg;
   wire fw_tick;
   wire [5:0] half_last;

   // Selection clock source and divide ratio
   always @* begin
      pre_sel = `PRE_DIV2;
      use_ext = 1'b0;
      ratio = `M_44;
      legal = 1'b1;
      casez ({expansion, speed_mode, div_hi, div_lo})
         4'b0000: ratio = `M_44;
         4'b0001: ratio = `M_86;
         4'b0010: begin
            pre_sel = `PRE_DIV4;
            ratio = `M_86;
         end
         4'b0011: begin
            use_ext = 1'b1;
            ratio = `M_66;
         end
         4'b010?: ratio = `M_24;
         4'b0110: begin
            pre_sel = `PRE_DIV4;
            ratio = `M_24;
         end
         4'b0111: begin
            use_ext = 1'b1;
            ratio = `M_18;
         end
         4'b110?: ratio = `M_12;
         4'b1110: begin
            pre_sel = `PRE_DIV4;
            ratio = `M_12;
         end
         default: legal = 1'b0;
      endcase
   end

   assign fw_tick = use_ext ? (ext_clk & ~ext_prev_reg)
      : (pre_cnt_reg == pre_sel - 3'h1);
   assign half_last = ratio[6:1] - 6'h01;

   // Idle high so a stopped clock never looks like a bit edge
   always @(posedge clock) begin
      if (reset) begin
         pre_cnt_reg <= 3'h0;
         ext_prev_reg <= 1'b0;
         half_cnt_reg <= 6'h00;
         xfer_clk <= 1'b1;
         clk_valid <= 1'b0;
      end else begin
         ext_prev_reg <= ext_clk;
         clk_valid <= run & legal;
         if (!(run && legal)) begin
            pre_cnt_reg <= 3'h0;
            half_cnt_reg <= 6'h00;
            xfer_clk <= 1'b1;
         end else begin
            if (fw_tick || use_ext)
               pre_cnt_reg <= 3'h0;
            else
               pre_cnt_reg <= pre_cnt_reg + 3'h1;
            if (fw_tick) begin
               if (half_cnt_reg >= half_last) begin
                  half_cnt_reg <= 6'h00;
                  xfer_clk <= ~xfer_clk;
               end else begin
                  half_cnt_reg <= half_cnt_reg + 6'h01;
               end
            end
         end
      end
   end

endmodule // xfer_clock_gen

// >>> hdl/i2c_flag_ctrl.v
`timescale 1ns/1ps
`include "i2c_flag_ctrl_map.vh"

module i2c_flag_ctrl (
   input wire CLOCK,          // System clock, 10 MHz
   input wire RESET,          // Synchronous reset, active high
   input wire [15:0] ADDR,    // CPU address
   input wire [7:0] WDATA,    // CPU write data
   input wire WRITE,          // Write strobe, one cycle
   input wire READ,           // Read strobe, one cycle
   output reg [7:0] RDATA,    // Read data, valid cycle after READ
   input wire SCL_IN,         // Clock line level
   input wire SDA_IN,         // Data line level
   input wire EXT_CLK_IN,     // External selection clock
   output reg START_GEN,      // Request to drive a start condition
   output reg BUS_BUSY,       // Bus busy flag
   output reg START_FAIL,     // Start failure flag
   output reg IF_ENABLE,      // Interface enabled
   output wire XFER_CLK,      // Transfer clock
   output wire XFER_CLK_VALID // Transfer clock running
);

   ////////////////////////////////////////////////////////////////////////
   // State
   reg enable_reg;
   reg start_req_reg;
   reg [5:0] ctrl_misc_reg;
   reg fail_reg;
   reg busy_reg;
   reg init_start_reg;
   reg rsv_dis_reg;
   reg [3:0] clk_sel_reg;
   reg clk_exp_reg;
   reg scl_prev_reg;
   reg sda_prev_reg;
   reg [1:0] level_reg;

   reg enable_next;
   reg start_req_next;
   reg [5:0] ctrl_misc_next;
   reg fail_next;
   reg busy_next;
   reg init_start_next;
   reg rsv_dis_next;
   reg [3:0] clk_sel_next;
   reg clk_exp_next;
   reg [7:0] read_mux;

   wire wr_flag;
   wire wr_ctrl;
   wire wr_clk_sel;
   wire wr_exp;
   wire start_seen;
   wire stop_seen;
   wire enable_rise;
   wire req_write;
   wire clk_level;
   wire data_level;
   wire [1:0] line_in;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign wr_flag = WRITE && (ADDR == `ADDR_BUS_FLAG);
   assign wr_ctrl = WRITE && (ADDR == `ADDR_IF_CTRL);
   assign wr_clk_sel = WRITE && (ADDR == `ADDR_CLK_SEL);
   assign wr_exp = WRITE && (ADDR == `ADDR_FUNC_EXP);

   // Inputs already synchronous; one stage of history is enough
   assign start_seen = enable_reg && scl_prev_reg && SCL_IN
      && sda_prev_reg && !SDA_IN;
   assign stop_seen = enable_reg && scl_prev_reg && SCL_IN
      && !sda_prev_reg && SDA_IN;

   assign enable_rise = enable_next && !enable_reg;
   assign req_write = wr_ctrl && WDATA[`IC_START_REQ];

   assign line_in = {SCL_IN, SDA_IN};
   assign clk_level = level_reg[1];
   assign data_level = level_reg[0];

   // Level bits only mean something while running, so they are held
   // low whenever the interface is stopped
   genvar li;
   generate
      for (li = 0; li < 2; li = li + 1) begin : g_level
         always @(posedge CLOCK) begin
            if (RESET)
               level_reg[li] <= 1'b0;
            else
               level_reg[li] <= enable_next & line_in[li];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always @* begin
      enable_next = enable_reg;
      start_req_next = start_req_reg;
      ctrl_misc_next = ctrl_misc_reg;
      fail_next = fail_reg;
      busy_next = busy_reg;
      init_start_next = init_start_reg;
      rsv_dis_next = rsv_dis_reg;
      clk_sel_next = clk_sel_reg;
      clk_exp_next = clk_exp_reg;

      if (wr_ctrl) begin
         enable_next = WDATA[`IC_ENABLE];
         ctrl_misc_next = {WDATA[6:2], WDATA[0]};
      end

      // Clock setup is stored as written; changing it mid-transfer is
      // the caller's hazard
      if (wr_clk_sel)
         clk_sel_next = WDATA[3:0];
      if (wr_exp)
         clk_exp_next = WDATA[`FX_CLK_EXP];

      // Start request: kept pending while the bus is busy and
      // reservation is on, so it fires once the bus is free
      if (req_write)
         start_req_next = 1'b1;
      else if (start_req_reg && start_seen)
         start_req_next = 1'b0;
      else if (start_req_reg && busy_reg && rsv_dis_reg)
         start_req_next = 1'b0;
      if (!enable_next)
         start_req_next = 1'b0;

      // Failure flag; a request write or a disable in the same cycle wins over a failure
      if (req_write)
         fail_next = 1'b0;
      if (!enable_next)
         fail_next = 1'b0;
      // A stopped interface never shows a failure
      if (enable_next && start_req_reg && !req_write
          && busy_reg && rsv_dis_reg)
         fail_next = 1'b1;

      // Initial start: software sets it while off, a stop clears it
      if (stop_seen)
         init_start_next = 1'b0;
      if (wr_flag && !enable_reg)
         init_start_next = WDATA[`BF_INIT_START];
      if (wr_flag && !enable_reg)
         rsv_dis_next = WDATA[`BF_RSV_DIS];

      // Bus busy
      if (start_seen)
         busy_next = 1'b1;
      if (stop_seen)
         busy_next = 1'b0;
      if (enable_rise && !init_start_reg)
         busy_next = 1'b1;
      if (enable_rise && init_start_reg)
         busy_next = 1'b0;
      if (!enable_next)
         busy_next = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always @(posedge CLOCK) begin
      if (RESET) begin
         enable_reg <= 1'b0;
         start_req_reg <= 1'b0;
         ctrl_misc_reg <= 6'h00;
         fail_reg <= 1'b0;
         busy_reg <= 1'b0;
         init_start_reg <= 1'b0;
         rsv_dis_reg <= 1'b0;
         clk_sel_reg <= 4'h0;
         clk_exp_reg <= 1'b0;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         enable_reg <= enable_next;
         start_req_reg <= start_req_next;
         ctrl_misc_reg <= ctrl_misc_next;
         fail_reg <= fail_next;
         busy_reg <= busy_next;
         init_start_reg <= init_start_next;
         rsv_dis_reg <= rsv_dis_next;
         clk_sel_reg <= clk_sel_next;
         clk_exp_reg <= clk_exp_next;
         scl_prev_reg <= SCL_IN;
         sda_prev_reg <= SDA_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   always @(posedge CLOCK) begin
      if (RESET) begin
         START_GEN <= 1'b0;
         BUS_BUSY <= 1'b0;
         START_FAIL <= 1'b0;
         IF_ENABLE <= 1'b0;
      end else begin
         // Start only on a released bus
         START_GEN <= start_req_next && !busy_next;
         BUS_BUSY <= busy_next;
         START_FAIL <= fail_next;
         IF_ENABLE <= enable_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path, unmapped addresses read zero
   always @* begin
      case (ADDR)
         `ADDR_BUS_FLAG:
            read_mux = {fail_reg, busy_reg, 4'h0,
                        init_start_reg, rsv_dis_reg};
         `ADDR_IF_CTRL:
            read_mux = {enable_reg, ctrl_misc_reg[5:1],
                        start_req_reg, ctrl_misc_reg[0]};
         `ADDR_CLK_SEL:
            read_mux = {2'h0, clk_level, data_level, clk_sel_reg};
         `ADDR_FUNC_EXP:
            read_mux = {7'h00, clk_exp_reg};
         default:
            read_mux = 8'h00;
      endcase
   end

   always @(posedge CLOCK) begin
      if (RESET)
         RDATA <= 8'h00;
      else if (READ)
         RDATA <= read_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer clock
   xfer_clock_gen u_clock (
      .clock(CLOCK),
      .reset(RESET),
      .run(enable_reg),
      .speed_mode(clk_sel_reg[`CS_SPEED_MODE]),
      .div_hi(clk_sel_reg[`CS_DIV_HI]),
      .div_lo(clk_sel_reg[`CS_DIV_LO]),
      .expansion(clk_exp_reg),
      .ext_clk(EXT_CLK_IN),
      .xfer_clk(XFER_CLK),
      .clk_valid(XFER_CLK_VALID)
   );

endmodule // i2c_flag_ctrl

// >>> bench/i2c_flag_ctrl_sva.sv
`timescale 1ns/1ps
module i2c_flag_ctrl_chk (
   input wire logic CLOCK, // System clock
   input wire logic RESET, // Synchronous reset
   input wire logic [15:0] ADDR, // CPU address
   input wire logic [7:0] WDATA, // Write data
   input wire logic WRITE, // Write strobe
   input wire logic READ, // Read strobe
   input wire logic [7:0] RDATA, // Read data
   input wire logic SCL_IN, // Clock line
   input wire logic SDA_IN, // Data line
   input wire logic EXT_CLK_IN, // External clock
   input wire logic START_GEN, // Start request out
   input wire logic BUS_BUSY, // Busy flag
   input wire logic START_FAIL, // Fail flag
   input wire logic IF_ENABLE, // Interface enable
   input wire logic XFER_CLK, // Transfer clock
   input wire logic XFER_CLK_VALID // Clock running
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////
   sequence start_cond;
      IF_ENABLE && SCL_IN && $past(SCL_IN) && $fell(SDA_IN);
   endsequence
   sequence stop_cond;
      IF_ENABLE && SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
   endsequence
   sequence req_write;
      WRITE && ADDR == 16'hffaa && WDATA[1] && IF_ENABLE;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_reset_clears: assert property (disable iff (1'b0) RESET |=>
      !BUS_BUSY && !START_FAIL && !START_GEN && !IF_ENABLE)
      else $error("Flags not cleared by reset");
   a_busy_on_start: assert property (start_cond |=> ##[0:1] BUS_BUSY)
      else $error("Busy not set by start condition");
   a_busy_off_stop: assert property (stop_cond |=> ##[0:1] !BUS_BUSY)
      else $error("Busy not cleared by stop condition");
   a_idle_no_busy: assert property (!IF_ENABLE |-> !BUS_BUSY)
      else $error("Busy while interface off");
   a_idle_no_fail: assert property (!IF_ENABLE |-> !START_FAIL)
      else $error("Fail flag while interface off");
   a_fail_req_clear: assert property (req_write |=> !START_FAIL)
      else $error("Fail flag not cleared by start request");
   a_fail_when_busy: assert property ($rose(START_FAIL) |->
      $past(BUS_BUSY) && !START_GEN)
      else $error("Fail flag set on released bus");
   a_gen_on_free: assert property ($rose(START_GEN) |-> !BUS_BUSY)
      else $error("Start issued on busy bus");
   a_rdata_hold: assert property (!$past(READ) && !$past(RESET) |->
      $stable(RDATA))
      else $error("Read data changed without read");
   a_clk_valid_en: assert property (XFER_CLK_VALID |->
      IF_ENABLE || $past(IF_ENABLE))
      else $error("Transfer clock valid while off");
endmodule // i2c_flag_ctrl_chk

// >>> bench/i2c_bus_peer.sv
`timescale 1ns/1ps
module i2c_bus_peer (
   input wire clock, // System clock
   output reg scl, // Clock line, pulled high
   output reg sda // Data line, pulled high
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Lines rise together so no false stop is seen
   task send_start;
      begin
         @(negedge clock) sda = 1'b1;
         scl = 1'b1;
         @(negedge clock) sda = 1'b0;
         @(negedge clock) scl = 1'b0;
      end
   endtask
   // Clock low first so data may fall safely
   task send_stop;
      begin
         @(negedge clock) scl = 1'b0;
         @(negedge clock) sda = 1'b0;
         @(negedge clock) scl = 1'b1;
         @(negedge clock) sda = 1'b1;
      end
   endtask
endmodule // i2c_bus_peer

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg wr_s = 1'b0;
   reg rd_s = 1'b0;
   reg ext_clk = 1'b0;
   reg [15:0] addr = 16'h0000;
   reg [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   wire scl, sda, sgen, busy, fail, en, xclk, xvalid;
   integer err_count = 0;
   integer total_checks = 0;
   integer n;
   i2c_flag_ctrl uut (.CLOCK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
      .WRITE(wr_s), .READ(rd_s), .RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda),
      .EXT_CLK_IN(ext_clk), .START_GEN(sgen), .BUS_BUSY(busy),
      .START_FAIL(fail), .IF_ENABLE(en), .XFER_CLK(xclk),
      .XFER_CLK_VALID(xvalid));
   i2c_bus_peer peer (.clock(clk), .scl(scl), .sda(sda));
   initial begin
      forever #50 clk = ~clk;
   end
   always @(negedge clk) ext_clk <= ~ext_clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(negedge clk) addr = a;
         wdata = d;
         wr_s = 1'b1;
         @(negedge clk) wr_s = 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [7:0] e);
      begin
         @(negedge clk) addr = a;
         rd_s = 1'b1;
         @(negedge clk) rd_s = 1'b0;
         chk(rdata, e);
      end
   endtask
   task idle;
      repeat (3) @(negedge clk);
   endtask
   task cnt(input integer c);
      reg prev;
      begin
         n = 0;
         prev = xclk;
         repeat (c) begin
            @(negedge clk);
            if (xclk !== prev)
               n = n + 1;
            prev = xclk;
         end
      end
   endtask
   task print_verdict;
      begin
         $display("Checks %0d, errors %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      begin
         rd(16'hffab, 8'h00);
         rd(16'hff48, 8'h00);
         rd(16'hff00, 8'h00);
         wr(16'hffab, 8'hff);
         rd(16'hffab, 8'h03);
         wr(16'hffab, 8'h00);
      end
   endtask
   task t_busy;
      begin
         wr(16'hffaa, 8'h80);
         chk({en, busy}, 8'h03);
         rd(16'hffab, 8'h40);
         wr(16'hffaa, 8'h82);
         idle;
         chk(sgen, 8'h00);
         peer.send_stop;
         idle;
         chk({busy, sgen}, 8'h01);
         peer.send_start;
         idle;
         chk({busy, sgen}, 8'h02);
         wr(16'hffaa, 8'h00);
         chk(busy, 8'h00);
      end
   endtask
   task t_init;
      begin
         wr(16'hffab, 8'h02);
         wr(16'hffaa, 8'h80);
         chk(busy, 8'h00);
         rd(16'hffab, 8'h02);
         wr(16'hffaa, 8'h82);
         idle;
         chk(sgen, 8'h01);
         peer.send_start;
         peer.send_stop;
         idle;
         rd(16'hffab, 8'h00);
         wr(16'hffaa, 8'h00);
      end
   endtask
   task t_fail;
      begin
         wr(16'hffab, 8'h01);
         wr(16'hffaa, 8'h80);
         wr(16'hffaa, 8'h82);
         idle;
         chk({fail, sgen}, 8'h02);
         rd(16'hffab, 8'hc1);
         wr(16'hffab, 8'h00);
         rd(16'hffab, 8'hc1);
         wr(16'hffaa, 8'h00);
         chk({fail, busy}, 8'h00);
         wr(16'hffab, 8'h00);
      end
   endtask
   task t_clock;
      begin
         wr(16'hff48, 8'hff);
         rd(16'hff48, 8'h0f);
         wr(16'hff48, 8'h00);
         wr(16'hffaa, 8'h80);
         idle;
         chk(xvalid, 8'h01);
         rd(16'hff48, 8'h30);
         cnt(250);
         chk(n[7:0], 8'h05);
         wr(16'hffaa, 8'h00);
         wr(16'hff48, 8'h03);
         wr(16'hffaa, 8'h80);
         idle;
         cnt(250);
         chk(n[7:0], 8'h03);
         wr(16'hffaa, 8'h00);
         wr(16'hff48, 8'h00);
         wr(16'hffa9, 8'h01);
         wr(16'hffaa, 8'h80);
         idle;
         chk({xvalid, xclk}, 8'h01);
         wr(16'hffaa, 8'h00);
         wr(16'hffa9, 8'h00);
      end
   endtask
   task t_rst;
      begin
         wr(16'hff48, 8'h0b);
         wr(16'hffaa, 8'h82);
         idle;
         chk({en, busy}, 8'h03);
         @(negedge clk) rst = 1'b1;
         repeat (2) @(negedge clk);
         rst = 1'b0;
         chk({en, busy, fail, sgen}, 8'h00);
         chk(rdata, 8'h00);
         rd(16'hff48, 8'h00);
         rd(16'hffab, 8'h00);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_busy;
      t_init;
      t_fail;
      t_clock;
      t_rst;
      print_verdict;
   end
   // Whole run is under two thousand cycles
   initial begin
      #500000;
      err_count = err_count + 1;
      print_verdict;
   end
endmodule // tb_top

bind i2c_flag_ctrl i2c_flag_ctrl_chk chk_inst (.CLOCK(CLOCK), .RESET(RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
   .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .EXT_CLK_IN(EXT_CLK_IN),
   .START_GEN(START_GEN), .BUS_BUSY(BUS_BUSY), .START_FAIL(START_FAIL),
   .IF_ENABLE(IF_ENABLE), .XFER_CLK(XFER_CLK),
   .XFER_CLK_VALID(XFER_CLK_VALID));
